// ===== ipx_bus_master.sv
// Behavioural two-wire bus master that drives the expander in the bench.
`timescale 1ns/10ps
module ipx_bus_master (
   input wire logic core_clk_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic sda_pull_out,
   output logic got_stb_out,
   output logic [7:0] got_val_out
);
   // ---------------------------------------------
   // Bit level: 8 core cycles per 160 ns SCL period
   // ---------------------------------------------
   // Both lines released at idle; SCL stands still between frames
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
      got_stb_out = 1'b0;
      got_val_out = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // SDA moves only while SCL is low; read late in the high phase for margin
   task automatic clk_bit(input logic b, output logic s);
      scl_out <= 1'b0;
      tick(2);
      sda_pull_out <= ~b;
      tick(2);
      scl_out <= 1'b1;
      tick(3);
      s = sda_in;
      tick(1);
   endtask
   // Received value goes to the bench monitor as a one-cycle strobe
   task automatic report(input logic [7:0] v);
      got_val_out <= v;
      got_stb_out <= 1'b1;
      tick(1);
      got_stb_out <= 1'b0;
   endtask
   task automatic start_cond();
      sda_pull_out <= 1'b1;
      tick(4);
   endtask
   task automatic stop_cond();
      scl_out <= 1'b0;
      tick(2);
      sda_pull_out <= 1'b1;
      tick(2);
      scl_out <= 1'b1;
      tick(4);
      sda_pull_out <= 1'b0;
      tick(4);
   endtask
   // Byte out MSB first, then the ninth clock samples the slave's answer
   task automatic wr_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
      clk_bit(1'b1, s);
      report({7'h00, s});
   endtask
   // Byte in; master pulls SDA on the ninth clock unless it is the last
   task automatic rd_byte(input logic last);
      logic [7:0] v;
      logic s;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
      report(v);
      clk_bit(last, s);
   endtask
endmodule

// ===== ipx_expander.sv
// Two-wire slave transaction logic of the eight-bit port expander.
`timescale 1ns/10ps
module ipx_expander
   import ipx_pkg::*;
#(
   parameter int PORT_W = IPX_PORT_W
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic addr_select_0_in,
   input wire logic addr_select_1_in,
   input wire logic addr_select_2_in,
   input wire logic [PORT_W-1:0] port_pins_in,
   output logic [PORT_W-1:0] port_pins_out,
   output logic [PORT_W-1:0] port_pins_oe_out,
   output logic alert_n_out,
   output logic alert_n_oe_out
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int SW = PORT_W + 5;
   logic [SW-1:0] sync_w;
   ipx_sync #(.WIDTH(SW)) u_sync (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({scl_in, sda_in, addr_select_2_in, addr_select_1_in,
                 addr_select_0_in, port_pins_in}),
      .reset_val_in({1'b1, 1'b1, 3'h0, IPX_PORT_RESET}),
      .sync_out(sync_w)
   );
   wire scl_s = sync_w[SW-1];
   wire sda_s = sync_w[SW-2];
   wire [2:0] asel_s = sync_w[SW-3:SW-5];
   wire [PORT_W-1:0] pins_s = sync_w[PORT_W-1:0];

   // ----------------------------------------------------------------
   // Edge and condition detection
   // ----------------------------------------------------------------
   logic scl_d_reg;
   logic sda_d_reg;
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   wire scl_rise = scl_s && !scl_d_reg;
   wire scl_fall = !scl_s && scl_d_reg;
   // START and STOP are SDA edges while SCL stays high
   wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;

   // ----------------------------------------------------------------
   // Transaction state
   // ----------------------------------------------------------------
   ipx_state_t state_reg, state_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next;
   logic [PORT_W-1:0] tx_reg, tx_next;
   logic rw_reg, rw_next;
   logic master_nak_reg, master_nak_next;
   logic [PORT_W-1:0] out_reg, out_next;
   logic [PORT_W-1:0] snap_reg, snap_next;
   logic hold_reg, hold_next;
   logic sda_low_reg, sda_low_next;

   wire [6:0] own_addr = {IPX_ADDR_FIXED, asel_s};
   wire addr_match = (shift_reg[7:1] == own_addr);
   wire byte_done = (bit_reg == IPX_BIT_LAST);
   // Address byte is complete only at the fall after its eighth rise
   wire addr_done = (bit_reg == IPX_BIT_LAST + 4'h1);
   wire wr_ack_fall = (state_reg == IPX_WR_ACK) && scl_fall;
   wire rd_ack_rise = (state_reg == IPX_RD_ACK) && scl_rise;
   wire rd_ack_fall = (state_reg == IPX_RD_ACK) && scl_fall;
   wire wr_byte_end = (state_reg == IPX_WR_DATA) && scl_fall && byte_done;
   wire addr_rd_ack = (state_reg == IPX_ADDR_ACK) && rw_reg;
   wire change = (pins_s != snap_reg);

   // Next-state logic; bytes are sampled on SCL rise and SDA moves on SCL fall
   always_comb begin
      state_next = state_reg;
      bit_next = bit_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      rw_next = rw_reg;
      master_nak_next = master_nak_reg;
      out_next = out_reg;
      snap_next = snap_reg;
      sda_low_next = sda_low_reg;
      unique case (state_reg)
         IPX_IDLE: begin
            sda_low_next = 1'b0;
         end
         IPX_ADDR: begin
            if (scl_rise) begin
               shift_next = {shift_reg[6:0], sda_s};
               bit_next = bit_reg + 4'h1;
            end else if (scl_fall && addr_done) begin
               // Not our address: stay off SDA until the next START
               if (addr_match) begin
                  state_next = IPX_ADDR_ACK;
                  rw_next = shift_reg[0];
                  sda_low_next = 1'b1;
               end else begin
                  state_next = IPX_IDLE;
               end
            end
         end
         IPX_ADDR_ACK: begin
            if (rw_reg && scl_rise) begin
               tx_next = pins_s;
            end
            if (scl_fall) begin
               bit_next = IPX_BIT_ZERO;
               if (rw_reg) begin
                  state_next = IPX_RD_DATA;
                  sda_low_next = ~tx_reg[PORT_W-1];
               end else begin
                  state_next = IPX_WR_DATA;
                  sda_low_next = 1'b0;
               end
            end
         end
         IPX_WR_DATA: begin
            if (scl_rise) begin
               shift_next = {shift_reg[6:0], sda_s};
            end else if (scl_fall) begin
               if (byte_done) begin
                  state_next = IPX_WR_ACK;
                  sda_low_next = 1'b1;
                  out_next = shift_reg;
               end
               bit_next = bit_reg + 4'h1;
            end
         end
         IPX_WR_ACK: begin
            if (scl_fall) begin
               state_next = IPX_WR_DATA;
               bit_next = IPX_BIT_ZERO;
               sda_low_next = 1'b0;
               snap_next = pins_s;
            end
         end
         IPX_RD_DATA: begin
            if (scl_fall) begin
               if (byte_done) begin
                  state_next = IPX_RD_ACK;
                  sda_low_next = 1'b0;
               end else begin
                  sda_low_next = ~tx_reg[PORT_W-2-bit_reg[2:0]];
               end
               bit_next = bit_reg + 4'h1;
            end
         end
         IPX_RD_ACK: begin
            if (scl_rise) begin
               master_nak_next = sda_s;
               snap_next = tx_reg;
            end
            if (scl_fall) begin
               bit_next = IPX_BIT_ZERO;
               if (master_nak_reg) begin
                  state_next = IPX_IDLE;
               end else begin
                  state_next = IPX_RD_DATA;
                  tx_next = pins_s;
                  sda_low_next = ~pins_s[PORT_W-1];
               end
            end
         end
      endcase
      if (start_det) begin
         state_next = IPX_ADDR;
         bit_next = IPX_BIT_ZERO;
         sda_low_next = 1'b0;
      end else if (stop_det) begin
         state_next = IPX_IDLE;
         sda_low_next = 1'b0;
      end
   end

   // Alert hold: set by read acknowledge, dropped only by STOP
   always_comb begin
      hold_next = hold_reg;
      if (rd_ack_rise) begin
         hold_next = 1'b1;
      end else if (stop_det) begin
         hold_next = 1'b0;
      end
   end

   // Registers
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= IPX_IDLE;
         bit_reg <= IPX_BIT_ZERO;
         shift_reg <= 8'h00;
         tx_reg <= IPX_PORT_RESET;
         rw_reg <= 1'b0;
         master_nak_reg <= 1'b0;
         out_reg <= IPX_PORT_RESET;
         snap_reg <= IPX_PORT_RESET;
         hold_reg <= 1'b0;
         sda_low_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         rw_reg <= rw_next;
         master_nak_reg <= master_nak_next;
         out_reg <= out_next;
         snap_reg <= snap_next;
         hold_reg <= hold_next;
         sda_low_reg <= sda_low_next;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers (open drain: drive low only)
   // ----------------------------------------------------------------
   assign sda_out = 1'b0;
   assign sda_oe_out = sda_low_reg;
   assign port_pins_out = {PORT_W{1'b0}};
   assign port_pins_oe_out = ~out_reg;
   // Alert compares live pins with the snapshot; suppressed while held
   wire alert_act = change && !hold_reg;
   assign alert_n_out = 1'b0;
   assign alert_n_oe_out = alert_act;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   addr_ack_drive_a: assert property ((state_reg == IPX_ADDR_ACK) |-> sda_oe_out)
      else $error("address acknowledge not driven");
   snap_on_ack_a: assert property (addr_rd_ack && scl_rise |=> tx_reg == $past(pins_s))
      else $error("read snapshot not taken");
   rd_hold_set_a: assert property (rd_ack_rise |=> hold_reg)
      else $error("alert not released at read acknowledge");
   snap_equal_tx_a: assert property (rd_ack_rise |=> snap_reg == $past(tx_reg))
      else $error("reference not set to sent data");
   hold_till_stop_a: assert property (hold_reg && !stop_det |=> hold_reg)
      else $error("alert hold dropped before stop");
   rd_reload_a: assert property (rd_ack_fall && !master_nak_reg
         |=> tx_reg == $past(pins_s))
      else $error("next read byte not taken from pins");
   wr_ack_drive_a: assert property ((state_reg == IPX_WR_ACK) |-> sda_oe_out)
      else $error("write byte not acknowledged");
   wr_clear_a: assert property (wr_ack_fall |=> snap_reg == $past(pins_s))
      else $error("write did not clear alert");
   alert_cause_a: assert property (alert_n_oe_out |-> (pins_s != snap_reg) && !hold_reg)
      else $error("alert without change");
   idle_quiet_a: assert property ((state_reg == IPX_IDLE) |-> !sda_oe_out)
      else $error("SDA driven while idle");
   port_drive_a: assert property (wr_byte_end
         |=> port_pins_oe_out == ~$past(shift_reg))
      else $error("port drive mismatch");
   read_seen_c: cover property (rd_ack_rise);
   write_seen_c: cover property (wr_ack_fall);
   alert_seen_c: cover property (alert_n_oe_out);
   nomatch_c: cover property ((state_reg == IPX_ADDR) ##1 (state_reg == IPX_IDLE));
endmodule

// ===== ipx_expander_tb_top.sv
// Self-checking bench for the port expander transaction logic.
`timescale 1ns/10ps
module ipx_expander_tb_top;
   import ipx_pkg::*;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [2:0] addr_sel = 3'h0;
   logic [7:0] ext_pins = 8'hFF;
   logic [31:0] lfsr = 32'h0001_2870;
   logic [7:0] exp_q[$];
   logic [7:0] a_wr, a_rd, p, q;
   int err_total = 0;
   int comparisons = 0;
   wire scl, m_pull, got_stb, sda_oe, alert_oe;
   wire [7:0] got_val, pins_oe;
   // Open-drain wires with pull-ups: low only while someone pulls
   wire sda_line = ~(m_pull | sda_oe);
   wire [7:0] pin_line = ext_pins & ~pins_oe;
   always #10 core_clk_in = ~core_clk_in;
   ipx_expander #(.PORT_W(IPX_PORT_W)) dut_u (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda_line), .sda_out(),
      .sda_oe_out(sda_oe), .addr_select_0_in(addr_sel[0]), .addr_select_1_in(addr_sel[1]),
      .addr_select_2_in(addr_sel[2]), .port_pins_in(pin_line), .port_pins_out(),
      .port_pins_oe_out(pins_oe), .alert_n_out(), .alert_n_oe_out(alert_oe));
   ipx_bus_master master_u (.core_clk_in(core_clk_in), .sda_in(sda_line), .scl_out(scl),
      .sda_pull_out(m_pull), .got_stb_out(got_stb), .got_val_out(got_val));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         err_total++;
         $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic tally_and_finish();
      if (exp_q.size() != 0) err_total++;
      $display("comparisons=%0d err_total=%0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Expected answer is queued before the master starts the byte
   task automatic send(input logic [7:0] b, input logic [7:0] want_ack);
      exp_q.push_back(want_ack);
      master_u.wr_byte(b);
   endtask
   task automatic recv(input logic [7:0] want, input logic last);
      exp_q.push_back(want);
      master_u.rd_byte(last);
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // Monitor: every reported bus value is matched against the oldest note
   always @(posedge core_clk_in) begin
      if (got_stb === 1'b1) check(got_val, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hEE);
   end
   // Watchdog: whole run is about 1200 cycles, so this margin is generous
   initial begin
      #400000;
      err_total++;
      tally_and_finish();
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      wait_clk(5);
      lfsr = lfsr_next(lfsr);
      addr_sel <= lfsr[2:0];
      sys_rst_in <= 1'b0;
      a_wr = {IPX_ADDR_FIXED, lfsr[2:0], 1'b0};
      a_rd = {IPX_ADDR_FIXED, lfsr[2:0], 1'b1};
      wait_clk(8);
      check(pins_oe, 8'h00);
      check({7'h00, alert_oe}, 8'h00);
      // Test 1: two-byte write, the last byte sets the port
      lfsr = lfsr_next(lfsr);
      master_u.start_cond();
      send(a_wr, 8'h00);
      send(lfsr[7:0], 8'h00);
      send(lfsr[15:8], 8'h00);
      master_u.stop_cond();
      check(pins_oe, ~lfsr[15:8]);
      $display("test 1 done");
      // Test 2: all ports as inputs, edge raises alert, one-byte read
      master_u.start_cond();
      send(a_wr, 8'h00);
      send(8'hFF, 8'h00);
      master_u.stop_cond();
      lfsr = lfsr_next(lfsr);
      p = lfsr[7:0] & 8'h7E;
      ext_pins <= p;
      wait_clk(10);
      check({7'h00, alert_oe}, 8'h01);
      master_u.start_cond();
      send(a_rd, 8'h00);
      ext_pins <= p ^ 8'h0F;
      recv(p, 1'b1);
      check({7'h00, alert_oe}, 8'h00);
      wait_clk(10);
      check({7'h00, alert_oe}, 8'h00);
      master_u.stop_cond();
      wait_clk(6);
      check({7'h00, alert_oe}, 8'h01);
      $display("test 2 done");
      // Test 3: two-byte read, second byte shows the newer pin levels
      p = p ^ 8'h0F;
      q = p ^ 8'hF0;
      master_u.start_cond();
      send(a_rd, 8'h00);
      ext_pins <= q;
      recv(p, 1'b0);
      recv(q, 1'b1);
      master_u.stop_cond();
      wait_clk(6);
      check({7'h00, alert_oe}, 8'h00);
      $display("test 3 done");
      // Test 4: a write clears a pending alert
      ext_pins <= q ^ 8'h81;
      wait_clk(10);
      check({7'h00, alert_oe}, 8'h01);
      master_u.start_cond();
      send(a_wr, 8'h00);
      send(8'hFF, 8'h00);
      master_u.stop_cond();
      check({7'h00, alert_oe}, 8'h00);
      $display("test 4 done");
      // Test 5: foreign address is ignored, data byte must not reach the port
      master_u.start_cond();
      send({IPX_ADDR_FIXED, addr_sel ^ 3'h5, 1'b0}, 8'h01);
      send(8'h00, 8'h01);
      master_u.stop_cond();
      check(pins_oe, 8'h00);
      $display("test 5 done");
      wait_clk(4);
      tally_and_finish();
   end
endmodule

// ===== ipx_pkg.sv
// Package of constants for the two-wire port expander transaction logic.
// Operation
// - Acknowledge own address with read bit; snapshot port pins during that acknowledge.
// - One-byte read then STOP sends current port levels and re-arms detection.
// - Read releases change alert high during the port data byte acknowledge.
// - Reference snapshot equals transmitted data so changes during sending are caught.
// - After release in a read, alert stays high until STOP.
// - Each further read byte sends the current port levels again.
// - Write transfer: acknowledge address and every data byte until STOP.
// - Seven-bit address: four fixed upper bits, three from select inputs; R/W follows.
// - Written byte drives each port bit; master writes high for inputs.
// - Assert alert on any port edge relative to stored snapshot.
// - Write transfer clears alert at data byte acknowledge on falling SCL.
package ipx_pkg;
   // ----------------------------------------------------------------
   // Bus constants
   // ----------------------------------------------------------------
   localparam int IPX_PORT_W = 8;
   localparam logic [3:0] IPX_ADDR_FIXED = 4'h4;
   localparam logic [IPX_PORT_W-1:0] IPX_PORT_RESET = 8'hFF;
   localparam logic [3:0] IPX_BIT_LAST = 4'h7;
   localparam logic [3:0] IPX_BIT_ZERO = 4'h0;
   localparam int IPX_SYNC_STAGES = 2;
   typedef enum logic [2:0] {
      IPX_IDLE, IPX_ADDR, IPX_ADDR_ACK, IPX_WR_DATA, IPX_WR_ACK,
      IPX_RD_DATA, IPX_RD_ACK
   } ipx_state_t;
endpackage

// ===== ipx_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/10ps
module ipx_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] async_in,
   input wire logic [WIDTH-1:0] reset_val_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   // Synchronous reset, so loading a port value at reset is legal
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         meta_reg <= reset_val_in;
         sync_out <= reset_val_in;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
